// ### rtl/tsr_pkg.sv
package tsr_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] TSR_IDX_PART_IDENTITY     = 8'h00;
  localparam logic [7:0] TSR_IDX_FIRMWARE_VERSION  = 8'h01;
  localparam logic [7:0] TSR_IDX_SYSTEM_STATE_BITS = 8'h10;
  localparam logic [7:0] TSR_IDX_DETECTION_STATE   = 8'h31;
  localparam logic [7:0] TSR_IDX_EVENT_STATUS      = 8'h50;
  localparam logic [7:0] TSR_IDX_EVENT_MASK        = 8'h51;

  // ==========================================================
  // field positions
  localparam int TSR_SYS_POLARITY   = 5;
  localparam int TSR_SYS_AVG_HALT   = 4;
  localparam int TSR_SYS_LOW_POWER  = 3;
  localparam int TSR_SYS_AUTO_TUNE  = 2;
  localparam int TSR_SYS_NOISE      = 1;
  localparam int TSR_SYS_ZOOM       = 0;
  localparam int TSR_DET_TOUCH      = 1;
  localparam int TSR_DET_PROX       = 0;

  localparam int TSR_EV_WIDTH       = 5;
  localparam int TSR_EV_PROX        = 0;
  localparam int TSR_EV_TOUCH       = 1;
  localparam int TSR_EV_NOISE       = 2;
  localparam int TSR_EV_TUNE_DONE   = 3;
  localparam int TSR_EV_ZOOM        = 4;

  // ==========================================================
  // reset values and bus codes
  localparam logic [7:0]  TSR_BYTE_RESET  = 8'h00;
  localparam logic [4:0]  TSR_EV_RESET    = 5'h00;
  localparam logic [31:0] TSR_WORD_RESET  = 32'h0000_0000;
  localparam logic [1:0]  TSR_AGE_SETTLED = 2'h3;
  localparam logic [1:0]  TSR_AGE_RESET   = 2'h0;
  localparam logic [2:0]  TSR_HSIZE_WORD  = 3'h2;
  localparam logic        TSR_HRESP_OKAY  = 1'h0;

  typedef enum logic [2:0] {
    TSR_PH_IDLE  = 3'h1,
    TSR_PH_READ  = 3'h2,
    TSR_PH_WRITE = 3'h4
  } tsr_phase_type;

  // {in_window, index}
  function automatic logic [8:0] tsr_decode(input logic [31:0] addr);
    tsr_decode = {(addr[31:10] == 22'h0) && (addr[1:0] == 2'h0), addr[9:2]};
  endfunction

endpackage

// ### rtl/tsr_event_capture.sv
`timescale 1ns/1ps
module tsr_event_capture
  import tsr_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic [TSR_EV_WIDTH-1:0] level_in,
  input  wire logic                    clear_we,
  input  wire logic                    mask_we,
  input  wire logic [TSR_EV_WIDTH-1:0] wr_data,
  output logic      [TSR_EV_WIDTH-1:0] status,
  output logic      [TSR_EV_WIDTH-1:0] mask,
  output logic                         irq
);

  typedef struct packed {
    logic                    primed;
    logic [TSR_EV_WIDTH-1:0] prev;
    logic [TSR_EV_WIDTH-1:0] status;
    logic [TSR_EV_WIDTH-1:0] mask;
  } tsr_capture_type;

  tsr_capture_type state;
  tsr_capture_type next_state;
  logic [TSR_EV_WIDTH-1:0] rise;

  // ==========================================================
  // rising edges; nothing fires on the first cycle out of reset
  always_comb begin
    next_state        = state;
    rise              = state.primed ? (level_in & ~state.prev) : TSR_EV_RESET;
    next_state.primed = 1'b1;
    next_state.prev   = level_in;
    // a new event outranks a clear in the same cycle
    next_state.status = (clear_we ? (state.status & ~wr_data) : state.status) | rise;
    if (mask_we) begin
      next_state.mask = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= '{primed: 1'b0, prev: TSR_EV_RESET, status: TSR_EV_RESET, mask: TSR_EV_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign status = state.status;
  assign mask   = state.mask;
  assign irq    = |(state.status & state.mask);

endmodule

// ### rtl/tsr_read_port.sv
`timescale 1ns/1ps
module tsr_read_port
  import tsr_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    load,
  input  wire logic                    in_window,
  input  wire logic [7:0]              index,
  input  wire logic [7:0]              part_code,
  input  wire logic [7:0]              fw_code,
  input  wire logic [7:0]              sys_bits,
  input  wire logic [7:0]              det_bits,
  input  wire logic [TSR_EV_WIDTH-1:0] ev_status,
  input  wire logic [TSR_EV_WIDTH-1:0] ev_mask,
  output logic      [31:0]             rdata
);

  typedef struct packed {
    logic [31:0] data;
  } tsr_rdport_type;

  tsr_rdport_type state;
  tsr_rdport_type next_state;
  logic [31:0]    word;

  // ==========================================================
  // unmapped words read as zero
  always_comb begin
    word = TSR_WORD_RESET;
    if (in_window) begin
      case (index)
        TSR_IDX_PART_IDENTITY:     word = {24'h0, part_code};
        TSR_IDX_FIRMWARE_VERSION:  word = {24'h0, fw_code};
        TSR_IDX_SYSTEM_STATE_BITS: word = {24'h0, sys_bits};
        TSR_IDX_DETECTION_STATE:   word = {24'h0, det_bits};
        TSR_IDX_EVENT_STATUS:      word = {27'h0, ev_status};
        TSR_IDX_EVENT_MASK:        word = {27'h0, ev_mask};
        default:                   word = TSR_WORD_RESET;
      endcase
    end
    next_state      = state;
    if (load) begin
      next_state.data = word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= '{data: TSR_WORD_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.data;

endmodule

// ### rtl/tsr_status_bank.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module tsr_status_bank
  import tsr_pkg::*;
#(
  parameter logic [7:0] PART_NUMBER_CODE = 8'ha5, // arbitrary value
  parameter logic [7:0] FIRMWARE_VERSION = 8'h01  // arbitrary value
)(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // sensing core, same clock
  input  wire logic        outputs_active_high,
  input  wire logic        average_halted,
  input  wire logic        low_power_sample,
  input  wire logic        auto_tune_busy,
  input  wire logic        noise_detected,
  input  wire logic        zoom_active,
  input  wire logic        touch_detected,
  input  wire logic        prox_detected,
  // outputs
  output logic             full_speed_charge_req,
  output logic             irq
);

  // ==========================================================
  // state
  typedef struct packed {
    tsr_phase_type phase;
    logic          wr_hit;
    logic [7:0]    wr_index;
    logic [7:0]    sys_bits;
    logic [7:0]    det_bits;
    logic          charge_fast;
    logic [1:0]    age;
  } tsr_bank_type;

  tsr_bank_type            state;
  tsr_bank_type            next_state;
  logic [8:0]              dec;
  logic                    accept;
  logic                    rd_load;
  logic                    clear_we;
  logic                    mask_we;
  logic [TSR_EV_WIDTH-1:0] ev_level;
  logic [TSR_EV_WIDTH-1:0] ev_status;
  logic [TSR_EV_WIDTH-1:0] ev_mask;

  assign dec     = tsr_decode(haddr);
  assign accept  = hsel && hready && htrans[1];
  assign rd_load = accept && !hwrite;

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    // snapshot so one read sees a coherent byte
    next_state.sys_bits = TSR_BYTE_RESET;
    next_state.sys_bits[TSR_SYS_POLARITY]  = outputs_active_high;
    next_state.sys_bits[TSR_SYS_AVG_HALT]  = average_halted;
    next_state.sys_bits[TSR_SYS_LOW_POWER] = low_power_sample;
    next_state.sys_bits[TSR_SYS_AUTO_TUNE] = auto_tune_busy;
    next_state.sys_bits[TSR_SYS_NOISE]     = noise_detected;
    next_state.sys_bits[TSR_SYS_ZOOM]      = zoom_active;
    next_state.det_bits = TSR_BYTE_RESET;
    next_state.det_bits[TSR_DET_TOUCH] = touch_detected;
    next_state.det_bits[TSR_DET_PROX]  = prox_detected;
    // boost sampling already charges at full speed
    next_state.charge_fast = zoom_active && low_power_sample;
    if (state.age != TSR_AGE_SETTLED) begin
      next_state.age = state.age + 2'h1;
    end
    case (state.phase)
      TSR_PH_IDLE, TSR_PH_READ, TSR_PH_WRITE: begin
        next_state.phase  = TSR_PH_IDLE;
        next_state.wr_hit = 1'b0;
        if (accept) begin
          next_state.phase    = hwrite ? TSR_PH_WRITE : TSR_PH_READ;
          next_state.wr_hit   = hwrite && dec[8] && (hsize == TSR_HSIZE_WORD);
          next_state.wr_index = dec[7:0];
        end
      end
      default: begin
        next_state.phase  = TSR_PH_IDLE;
        next_state.wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= '{phase: TSR_PH_IDLE, wr_hit: 1'b0, wr_index: TSR_BYTE_RESET,
                 sys_bits: TSR_BYTE_RESET, det_bits: TSR_BYTE_RESET,
                 charge_fast: 1'b0, age: TSR_AGE_RESET};
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // write data phase: only event status and mask take data
  always_comb begin
    clear_we = 1'b0;
    mask_we  = 1'b0;
    if (state.phase == TSR_PH_WRITE && state.wr_hit) begin
      clear_we = (state.wr_index == TSR_IDX_EVENT_STATUS);
      mask_we  = (state.wr_index == TSR_IDX_EVENT_MASK);
    end
  end

  // ==========================================================
  // events: tune-done is the falling edge of tuning busy
  always_comb begin
    ev_level                   = TSR_EV_RESET;
    ev_level[TSR_EV_PROX]      = prox_detected;
    ev_level[TSR_EV_TOUCH]     = touch_detected;
    ev_level[TSR_EV_NOISE]     = noise_detected;
    ev_level[TSR_EV_TUNE_DONE] = !auto_tune_busy;
    ev_level[TSR_EV_ZOOM]      = zoom_active;
  end

  tsr_event_capture u_events (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .level_in (ev_level),
    .clear_we (clear_we),
    .mask_we  (mask_we),
    .wr_data  (hwdata[TSR_EV_WIDTH-1:0]),
    .status   (ev_status),
    .mask     (ev_mask),
    .irq      (irq)
  );

  tsr_read_port u_read (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .load      (rd_load),
    .in_window (dec[8]),
    .index     (dec[7:0]),
    .part_code (PART_NUMBER_CODE),
    .fw_code   (FIRMWARE_VERSION),
    .sys_bits  (state.sys_bits),
    .det_bits  (state.det_bits),
    .ev_status (ev_status),
    .ev_mask   (ev_mask),
    .rdata     (hrdata)
  );

  // zero wait states; nothing is ever refused
  assign hreadyout             = 1'b1;
  assign hresp                 = TSR_HRESP_OKAY;
  assign full_speed_charge_req = state.charge_fast;

  // ==========================================================
  // assertions
  logic rd_part;
  logic rd_fw;
  logic rd_sys;
  logic rd_det;
  logic settled;

  assign rd_part = rd_load && dec[8] && (dec[7:0] == TSR_IDX_PART_IDENTITY);
  assign rd_fw   = rd_load && dec[8] && (dec[7:0] == TSR_IDX_FIRMWARE_VERSION);
  assign rd_sys  = rd_load && dec[8] && (dec[7:0] == TSR_IDX_SYSTEM_STATE_BITS);
  assign rd_det  = rd_load && dec[8] && (dec[7:0] == TSR_IDX_DETECTION_STATE);
  assign settled = (state.age == TSR_AGE_SETTLED);

  a_part_read:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_part |=> hrdata == {24'h0, PART_NUMBER_CODE})
    else $error("part number read wrong");

  a_fw_read:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_fw |=> hrdata == {24'h0, FIRMWARE_VERSION})
    else $error("firmware version read wrong");

  a_polarity_bit:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys && settled |=> hrdata[TSR_SYS_POLARITY] == $past(outputs_active_high, 2))
    else $error("polarity bit wrong");

  a_halt_bit:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys && settled |=> hrdata[TSR_SYS_AVG_HALT] == $past(average_halted, 2))
    else $error("halt bit wrong");

  a_low_power_bit:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys && settled |=> hrdata[TSR_SYS_LOW_POWER] == $past(low_power_sample, 2))
    else $error("low power bit wrong");

  a_tune_bit:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys && settled |=> hrdata[TSR_SYS_AUTO_TUNE] == $past(auto_tune_busy, 2))
    else $error("tuning bit wrong");

  a_noise_bit:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys && settled |=> hrdata[TSR_SYS_NOISE] == $past(noise_detected, 2))
    else $error("noise bit wrong");

  a_zoom_bit:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys && settled |=> hrdata[TSR_SYS_ZOOM] == $past(zoom_active, 2))
    else $error("zoom bit wrong");

  a_boost_no_speedup:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !low_power_sample |=> !full_speed_charge_req)
    else $error("charge rate changed in boost sampling");

  a_zoom_speedup:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      zoom_active && low_power_sample |=> full_speed_charge_req)
    else $error("fast charge not requested");

  a_detect_read:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_det && settled |=> hrdata == {30'h0, $past(touch_detected, 2), $past(prox_detected, 2)})
    else $error("detection byte wrong");

  a_ro_ignored:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      settled && state.phase == TSR_PH_WRITE
      |=> state.sys_bits[7:6] == 2'h0 && state.sys_bits[5:0] ==
          $past({outputs_active_high, average_halted, low_power_sample,
                 auto_tune_busy, noise_detected, zoom_active}))
    else $error("write disturbed read-only bits");

  a_bus_okay:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      hreadyout && hresp == TSR_HRESP_OKAY)
    else $error("bus stall or error");

  a_sys_reserved:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_sys |=> hrdata[31:6] == 26'h0)
    else $error("reserved system bits not zero");

  a_mask_kept:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      state.phase == TSR_PH_WRITE && state.wr_index != TSR_IDX_EVENT_MASK
      |=> ev_mask == $past(ev_mask))
    else $error("mask changed by another write");

  a_mask_load:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      mask_we |=> ev_mask == $past(hwdata[TSR_EV_WIDTH-1:0]))
    else $error("mask not loaded");

  a_status_clear:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      clear_we && $stable(ev_level)
      |=> (ev_status & $past(hwdata[TSR_EV_WIDTH-1:0])) == TSR_EV_RESET)
    else $error("status bit not cleared");

  a_status_sticky:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !clear_we |=> (ev_status & $past(ev_status)) == $past(ev_status))
    else $error("status bit dropped without clear");

  a_touch_event:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      settled && !touch_detected ##1 touch_detected |=> ev_status[TSR_EV_TOUCH])
    else $error("touch rise not captured");

  a_tune_done_event:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      settled && auto_tune_busy ##1 !auto_tune_busy |=> ev_status[TSR_EV_TUNE_DONE])
    else $error("tuning finish not captured");

  a_hrdata_hold:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !rd_load |=> $stable(hrdata))
    else $error("read data moved without a read");

  c_sys_read:
    cover property (@(posedge ref_clk) disable iff (sys_rst) rd_sys ##1 hrdata != 32'h0);
  c_irq_raise:
    cover property (@(posedge ref_clk) disable iff (sys_rst) !irq ##1 irq);
  c_status_clear:
    cover property (@(posedge ref_clk) disable iff (sys_rst) irq && clear_we ##1 !irq);
  c_fast_charge:
    cover property (@(posedge ref_clk) disable iff (sys_rst) full_speed_charge_req);
  c_tune_done:
    cover property (@(posedge ref_clk) disable iff (sys_rst) ev_status[TSR_EV_TUNE_DONE]);

endmodule

// ### bench/tsr_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side of the register bus: single word transfers only
module tsr_host_model
  import tsr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = TSR_HSIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // no wait count assumed; only the bench watchdog ends a stuck wait
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= TSR_HSIZE_WORD;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    // released lines show the inverse so stale values never match by luck
    haddr  <= ~haddr;
    if (wr) begin
      hwdata <= wd;
    end
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    if (wr) begin
      hwdata <= ~wd;
    end
  endtask
endmodule

// ### bench/tsr_status_bank_tb.sv
`timescale 1ns/1ps
module tsr_status_bank_tb
  import tsr_pkg::*;
;
  localparam logic [7:0] PART = 8'h5c; // arbitrary value
  localparam logic [7:0] FW   = 8'h3a; // arbitrary value

  logic        ref_clk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        outputs_active_high;
  logic        average_halted;
  logic        low_power_sample;
  logic        auto_tune_busy;
  logic        noise_detected;
  logic        zoom_active;
  logic        touch_detected;
  logic        prox_detected;
  logic        full_speed_charge_req;
  logic        irq;
  int          mismatches;
  int          comparisons;

  tsr_status_bank #(.PART_NUMBER_CODE(PART), .FIRMWARE_VERSION(FW)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .outputs_active_high(outputs_active_high), .average_halted(average_halted),
    .low_power_sample(low_power_sample), .auto_tune_busy(auto_tune_busy),
    .noise_detected(noise_detected), .zoom_active(zoom_active),
    .touch_detected(touch_detected), .prox_detected(prox_detected),
    .full_speed_charge_req(full_speed_charge_req), .irq(irq));

  tsr_host_model host (
    .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    host.xfer(idx, 1'b0, 32'h0000_0000, d);
    chk(name, exp, d);
    chk("hresp", {31'h0, TSR_HRESP_OKAY}, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    host.xfer(idx, 1'b1, wd, d);
  endtask

  // core flags change together; three edges let the snapshot settle
  task automatic core(input logic [5:0] s, input logic [1:0] d);
    @(posedge ref_clk);
    {outputs_active_high, average_halted, low_power_sample} <= s[5:3];
    {auto_tune_busy, noise_detected, zoom_active}       <= s[2:0];
    {touch_detected, prox_detected}                     <= d;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_and_ro();
    logic [7:0]  idx [5];
    logic [31:0] exp [5];
    idx = '{TSR_IDX_PART_IDENTITY, TSR_IDX_FIRMWARE_VERSION, TSR_IDX_SYSTEM_STATE_BITS,
            TSR_IDX_DETECTION_STATE, 8'h20};
    exp = '{{24'h0, PART}, {24'h0, FW}, TSR_WORD_RESET, TSR_WORD_RESET, TSR_WORD_RESET};
    rd_chk("event_status", TSR_IDX_EVENT_STATUS, TSR_WORD_RESET);
    rd_chk("event_mask", TSR_IDX_EVENT_MASK, TSR_WORD_RESET);
    chk("irq", 32'h0, {31'h0, irq});
    chk("fast_charge", 32'h0, {31'h0, full_speed_charge_req});
    for (int i = 0; i < 5; i++) begin
      rd_chk("ro_before", idx[i], exp[i]);
      wr(idx[i], 32'hffff_ffff);
      rd_chk("ro_after", idx[i], exp[i]);
    end
  endtask

  task automatic t_flags();
    for (int b = 0; b < 6; b++) begin
      core(6'(1 << b), 2'h0);
      rd_chk("system_state_bits", TSR_IDX_SYSTEM_STATE_BITS, 32'(1 << b));
    end
    for (int v = 0; v < 4; v++) begin
      core(6'h00, 2'(v));
      rd_chk("detection_state", TSR_IDX_DETECTION_STATE, 32'(v));
    end
    core(6'h09, 2'h0);
    chk("fast_charge", 32'h1, {31'h0, full_speed_charge_req});
    core(6'h01, 2'h0);
    // boost sampling already charges at full speed: no request
    chk("fast_charge", 32'h0, {31'h0, full_speed_charge_req});
    core(6'h00, 2'h0);
  endtask

  task automatic t_events();
    logic [7:0] stim [5];
    stim = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h04};
    wr(TSR_IDX_EVENT_STATUS, 32'h0000_001f);
    wr(TSR_IDX_EVENT_MASK, 32'h0000_001f);
    rd_chk("event_status", TSR_IDX_EVENT_STATUS, TSR_WORD_RESET);
    for (int b = 0; b < TSR_EV_WIDTH; b++) begin
      // raise then drop: rises give events, only the tuning busy fall does
      core(stim[b][7:2], stim[b][1:0]);
      core(6'h00, 2'h0);
      rd_chk("event_status", TSR_IDX_EVENT_STATUS, 32'(1 << b));
      chk("irq", 32'h1, {31'h0, irq});
      wr(TSR_IDX_EVENT_STATUS, 32'(1 << b));
      rd_chk("event_status", TSR_IDX_EVENT_STATUS, TSR_WORD_RESET);
      chk("irq", 32'h0, {31'h0, irq});
    end
    wr(TSR_IDX_EVENT_MASK, 32'h0000_0000);
    core(6'h00, 2'h1);
    core(6'h00, 2'h0);
    rd_chk("event_status", TSR_IDX_EVENT_STATUS, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    wr(TSR_IDX_EVENT_MASK, 32'h0000_0001);
    rd_chk("event_mask", TSR_IDX_EVENT_MASK, 32'h0000_0001);
    chk("irq", 32'h1, {31'h0, irq});
    wr(TSR_IDX_EVENT_STATUS, 32'h0000_0001);
    rd_chk("event_status", TSR_IDX_EVENT_STATUS, TSR_WORD_RESET);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // touch held high across a mid-run reset: no event may follow release
  task automatic t_mid_reset();
    wr(TSR_IDX_EVENT_MASK, 32'h0000_0003);
    core(6'h00, 2'h2);
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("event_status", TSR_IDX_EVENT_STATUS, TSR_WORD_RESET);
    rd_chk("event_mask", TSR_IDX_EVENT_MASK, TSR_WORD_RESET);
    rd_chk("detection_state", TSR_IDX_DETECTION_STATE, 32'h0000_0002);
    core(6'h00, 2'h0);
  endtask

  // ==========================================================
  // clock, reset, sequence, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    mismatches = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    {outputs_active_high, average_halted, low_power_sample} = 3'h0;
    {auto_tune_busy, noise_detected, zoom_active} = 3'h0;
    {touch_detected, prox_detected} = 2'h0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_and_ro();
    t_flags();
    t_events();
    t_mid_reset();
    results();
  end

  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    results();
  end
endmodule
